// ==== hw/dcs_pkg.sv ====
// package for the drive control/status word block
// assumes a single drive clock domain
package dcs_pkg;

    // ------------------------------------------------------------
    // aux command word bit positions
    // ------------------------------------------------------------
    localparam int AUX_FF_LSB     = 0;
    localparam int AUX_FF_MSB     = 3;
    localparam int AUX_TECH_EN    = 8;
    localparam int AUX_DCBRAKE_EN = 9;
    localparam int AUX_DROOP_EN   = 11;
    localparam int AUX_TORQUE_SEL = 12;
    localparam int AUX_EXTFLT_N   = 13;
    localparam int NUM_FUNCS      = 7;

    // ------------------------------------------------------------
    // primary command word bit positions
    // ------------------------------------------------------------
    localparam int CMD_ON       = 0;
    localparam int CMD_NOCOAST  = 1;
    localparam int CMD_NOQUICK  = 2;
    localparam int CMD_ENOP     = 3;
    localparam int CMD_ACK      = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] AUX_RESET   = 16'h2000;
    localparam logic [15:0] STATE_RESET = 16'h0000;
    localparam logic [15:0] PRI_RESET   = 16'h0000;

    // default source index for each aux function
    localparam logic [3:0] SRC_DEFAULT [NUM_FUNCS] =
        '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hB};
    localparam logic [3:0] SRC_TORQUE_DEF = 4'hC;
    localparam logic [3:0] SRC_EXTFLT_DEF = 4'hD;

    // drive conditions from the motor-control side
    typedef struct packed {
        logic powerOk;
        logic initDone;
        logic faultActive;
        logic alarmPending;
        logic speedInTol;
        logic ctrlRequest;
        logic freqAtMax;
        logic limitAlarm;
        logic brakeEngage;
        logic motorOverload;
        logic clockwise;
        logic convOverload;
    } dcs_cond_type;

    // decoded auxiliary functions
    typedef struct packed {
        logic [3:0] fixedFreqSel;
        logic       techEnable;
        logic       dcBrakeEnable;
        logic       droopEnable;
        logic       torqueMode;
        logic       extFault1;
    } dcs_aux_type;

endpackage

// ==== hw/dcs_bit_select.sv ====
// one reassignable routing stage: picks a bit of a word by index
// assumes index and word are on the drive clock
`timescale 1ns/1ns
`default_nettype none
module dcs_bit_select
    import dcs_pkg::*;
#(
    parameter int WIDTH = 16
)(
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic [WIDTH-1:0]         word,
    input  wire logic [$clog2(WIDTH)-1:0] index,
    input  wire logic                     resetValue,
    output var  logic                     bitOut
);

    // elaboration check: a one-bit word has nothing to select
    if (WIDTH < 2)
    begin : g_bad_width
        $error("dcs_bit_select: WIDTH must be at least 2");
    end

    wire logic pick = word[index];

    always_ff @(posedge clk)
    begin
        if (reset)
            bitOut <= resetValue;
        else
            bitOut <= pick;
    end

endmodule
`default_nettype wire

// ==== hw/dcs_words.sv ====
// drive control/status word block: aux command decode and state word
// assumes command words and conditions are on the drive clock
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - aux bits 0..3 select one fixed frequency, bit 0 least significant
// - aux bit 8 technology ctrl, bit 9 dc brake, bit 11 droop enable
// - aux bit 12 torque/speed; bit 13 low is external fault; rest ignored
// - each aux function source except dc brake and droop is reassignable by configuration index
// - state bit 0: power, init done, pulses still disabled, not in fault state
// - state bit 1: switch-on present and no active fault
// - state bit 2: operation enabled, follows enable-operation command
// - state bit 3: fault present; cleared and acknowledged goes to inhibit
// - state bits 4/5 low while coast-stop/fast-stop command present
// - state bit 6: switch-on inhibited until stops released and on command removed
// - state bit 7: alarm pending, no acknowledgement needed
// - state bit 8: speed deviation inside tolerance band
// - state bit 9: request master to take control
// - state bit 10: output frequency at or above maximum
// - state bit 11 low while current or torque limit alarm
// - state bit 12 high while holding brake engaged
// - state bit 13 low while motor overloaded
// - state bit 14 clockwise; bit 15 low on converter overload
// - bits 0..10 standard profile, 11..15 device specific
module dcs_words
    import dcs_pkg::*;
#(
    parameter int WORD_W = 16
)(
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               cmdValid,
    input  wire logic [WORD_W-1:0]  primaryCmdWord,
    input  wire logic [WORD_W-1:0]  auxCmdWrite,
    input  wire logic [4*NUM_FUNCS+7:0] srcConfig,
    input  wire dcs_cond_type       cond,
    output var  logic [WORD_W-1:0]  aux_command_word,
    output var  logic [WORD_W-1:0]  primary_state_word,
    output var  dcs_aux_type        auxFuncs,
    output var  logic               pulsesEnabled
);

    // elaboration check: bit map is fixed to a 16-bit word
    if (WORD_W != 16)
    begin : g_bad_word
        $error("dcs_words: WORD_W must be 16");
    end

    // ------------------------------------------------------------
    // command word capture
    // ------------------------------------------------------------
    logic [WORD_W-1:0] aux_q;
    logic [WORD_W-1:0] pri_q;
    logic              ackPrev_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            aux_q <= AUX_RESET;
            pri_q <= PRI_RESET;
        end
        else if (cmdValid)
        begin
            aux_q <= auxCmdWrite;
            pri_q <= primaryCmdWord;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            ackPrev_q <= 1'b0;
        else
            ackPrev_q <= pri_q[CMD_ACK];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            aux_command_word <= AUX_RESET;
        else
            aux_command_word <= aux_q;
    end

    // ------------------------------------------------------------
    // reassignable aux function routing
    // ------------------------------------------------------------
    logic [NUM_FUNCS-1:0] funcBit;
    logic [3:0]           srcIdx [NUM_FUNCS];

    // index field of zero-based config; all zero means use default
    wire logic cfgUseDefault = (srcConfig == '0);

    genvar g;
    generate
        for (g = 0; g < NUM_FUNCS; g++)
        begin : g_route
            assign srcIdx[g] = cfgUseDefault ?
                ((g < 5) ? SRC_DEFAULT[g] :
                 (g == 5) ? SRC_TORQUE_DEF : SRC_EXTFLT_DEF) :
                srcConfig[4*g+3 -: 4];
            dcs_bit_select #(
                .WIDTH (WORD_W)
            ) u_sel (
                .clk        (clk),
                .reset      (reset),
                .word       (aux_q),
                .index      (srcIdx[g]),
                .resetValue (AUX_RESET[AUX_EXTFLT_N] & (g == 6)),
                .bitOut     (funcBit[g])
            );
        end
    endgenerate

    // slots 0..3 freq select, 4 tech, 5 torque, 6 ext fault n;
    // dc brake and droop bypass routing via fixed bits below
    wire logic dcBrakeBit = aux_q[AUX_DCBRAKE_EN];
    wire logic droopBit   = aux_q[AUX_DROOP_EN];
    logic dcBrake_q;
    logic droop_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dcBrake_q <= 1'b0;
            droop_q   <= 1'b0;
        end
        else
        begin
            dcBrake_q <= dcBrakeBit;
            droop_q   <= droopBit;
        end
    end

    dcs_aux_type auxNext;
    assign auxNext.fixedFreqSel  = funcBit[3:0];
    assign auxNext.techEnable    = funcBit[4];
    assign auxNext.dcBrakeEnable = dcBrake_q;
    assign auxNext.droopEnable   = droop_q;
    assign auxNext.torqueMode    = funcBit[5];
    assign auxNext.extFault1     = ~funcBit[6];

    always_ff @(posedge clk)
    begin
        if (reset)
            auxFuncs <= '0;
        else
            auxFuncs <= auxNext;
    end

    // ------------------------------------------------------------
    // drive state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_NOTREADY,
        ST_INHIBIT,
        ST_READYON,
        ST_SWITCHEDON,
        ST_OPERATING,
        ST_FAULT
    } dcs_state_type;

    dcs_state_type state_q;
    dcs_state_type state_d;

    wire logic cmdOn      = pri_q[CMD_ON];
    wire logic noCoast    = pri_q[CMD_NOCOAST];
    wire logic noQuick    = pri_q[CMD_NOQUICK];
    wire logic enOp       = pri_q[CMD_ENOP];
    wire logic ackEdge    = pri_q[CMD_ACK] & ~ackPrev_q;
    wire logic powerReady = cond.powerOk & cond.initDone;
    wire logic stopsOff   = noCoast & noQuick;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_NOTREADY:
                if (powerReady)
                    state_d = ST_INHIBIT;
            ST_INHIBIT:
                if (stopsOff && !cmdOn && !cond.faultActive)
                    state_d = ST_READYON;
            ST_READYON:
                if (!stopsOff)
                    state_d = ST_INHIBIT;
                else if (cmdOn)
                    state_d = ST_SWITCHEDON;
            ST_SWITCHEDON:
                if (!stopsOff)
                    state_d = ST_INHIBIT;
                else if (!cmdOn)
                    state_d = ST_READYON;
                else if (enOp)
                    state_d = ST_OPERATING;
            ST_OPERATING:
                if (!stopsOff)
                    state_d = ST_INHIBIT;
                else if (!cmdOn)
                    state_d = ST_READYON;
                else if (!enOp)
                    state_d = ST_SWITCHEDON;
            ST_FAULT:
                if (!cond.faultActive && ackEdge)
                    state_d = ST_INHIBIT;
            default:
                state_d = ST_NOTREADY;
        endcase
        if (cond.faultActive)
            state_d = ST_FAULT;
        if (!powerReady)
            state_d = ST_NOTREADY;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            state_q <= ST_NOTREADY;
        else
            state_q <= state_d;
    end

    // ------------------------------------------------------------
    // state word assembly
    // ------------------------------------------------------------
    wire logic opEnabled = (state_q == ST_OPERATING);
    logic [WORD_W-1:0] stateNext;

    // bits 0..10 standard profile, 11..15 device specific
    assign stateNext[0]  = powerReady && !opEnabled
                           && (state_q != ST_FAULT);
    assign stateNext[1]  = (state_q == ST_SWITCHEDON
                           || opEnabled)
                           && !cond.faultActive;
    assign stateNext[2]  = opEnabled;
    assign stateNext[3]  = (state_q == ST_FAULT);
    assign stateNext[4]  = noCoast;
    assign stateNext[5]  = noQuick;
    assign stateNext[6]  = (state_q == ST_INHIBIT);
    assign stateNext[7]  = cond.alarmPending;
    assign stateNext[8]  = cond.speedInTol;
    assign stateNext[9]  = cond.ctrlRequest;
    assign stateNext[10] = cond.freqAtMax;
    assign stateNext[11] = ~cond.limitAlarm;
    assign stateNext[12] = cond.brakeEngage;
    assign stateNext[13] = ~cond.motorOverload;
    assign stateNext[14] = cond.clockwise;
    assign stateNext[15] = ~cond.convOverload;

    always_ff @(posedge clk)
    begin
        if (reset)
            primary_state_word <= STATE_RESET;
        else
            primary_state_word <= stateNext;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            pulsesEnabled <= 1'b0;
        else
            pulsesEnabled <= opEnabled;
    end

endmodule
`default_nettype wire

// ==== verif/dcs_words_checker.sv ====
// checker: port assertions for the control/status word block
// assumes it is bound into dcs_words, one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module dcs_words_checker
    import dcs_pkg::*;
#(
    parameter int WORD_W = 16
)(
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic                   cmdValid,
    input wire logic [WORD_W-1:0]      primaryCmdWord,
    input wire logic [WORD_W-1:0]      auxCmdWrite,
    input wire logic [4*NUM_FUNCS+7:0] srcConfig,
    input wire dcs_cond_type           cond,
    input wire logic [WORD_W-1:0]      aux_command_word,
    input wire logic [WORD_W-1:0]      primary_state_word,
    input wire dcs_aux_type            auxFuncs,
    input wire logic                   pulsesEnabled
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    wire logic [WORD_W-1:0] sw   = primary_state_word;
    wire logic              dflt = srcConfig == '0;
    dcs_cond_type           pc_q;
    always_ff @(posedge clk) pc_q <= cond;

    property p_ffSel;
        cmdValid && dflt ##3 dflt |->
            auxFuncs.fixedFreqSel == $past(auxCmdWrite[3:0], 3);
    endproperty
    a_ffSel: assert property (p_ffSel) else $error("freq select");
    property p_enables;
        cmdValid && dflt ##3 dflt |->
            auxFuncs.techEnable == $past(auxCmdWrite[8], 3) &&
            auxFuncs.dcBrakeEnable == $past(auxCmdWrite[9], 3) &&
            auxFuncs.droopEnable == $past(auxCmdWrite[11], 3);
    endproperty
    a_enables: assert property (p_enables) else $error("enables");
    property p_mode;
        cmdValid && dflt ##3 dflt |->
            auxFuncs.torqueMode == $past(auxCmdWrite[12], 3) &&
            auxFuncs.extFault1 != $past(auxCmdWrite[13], 3);
    endproperty
    a_mode: assert property (p_mode) else $error("mode or fault");
    property p_stops;
        cmdValid |-> ##2 sw[5:4] == $past(primaryCmdWord[2:1], 2);
    endproperty
    a_stops: assert property (p_stops) else $error("stop bits");
    property p_alarm;
        !$past(reset) |-> sw[7] == pc_q.alarmPending;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm bit");
    property p_hiBits;
        !$past(reset) |-> sw[14] == pc_q.clockwise &&
            sw[12] == pc_q.brakeEngage && sw[10] == pc_q.freqAtMax &&
            sw[9] == pc_q.ctrlRequest && sw[8] == pc_q.speedInTol;
    endproperty
    a_hiBits: assert property (p_hiBits) else $error("high bits");
    property p_loBits;
        !$past(reset) |-> sw[15] != pc_q.convOverload &&
            sw[13] != pc_q.motorOverload && sw[11] != pc_q.limitAlarm;
    endproperty
    a_loBits: assert property (p_loBits) else $error("low bits");
    property p_ready;
        sw[0] |-> !sw[2] && !pulsesEnabled;
    endproperty
    a_ready: assert property (p_ready) else $error("ready bit");
    property p_fault;
        sw[3] |-> !sw[1] && !sw[2] && !pulsesEnabled;
    endproperty
    a_fault: assert property (p_fault) else $error("fault bit");
endmodule
bind dcs_words dcs_words_checker #(.WORD_W(WORD_W)) dcs_words_checker_inst (
    .clk, .reset, .cmdValid, .primaryCmdWord, .auxCmdWrite, .srcConfig,
    .cond, .aux_command_word, .primary_state_word, .auxFuncs, .pulsesEnabled
);
`default_nettype wire

// ==== verif/dcs_master_model.sv ====
// fieldbus master model: issues the cyclic command words
// assumes the bench calls its tasks on the drive clock
`timescale 1ns/1ns
`default_nettype none
module dcs_master_model (
    input  wire logic        clk,
    output var  logic        cmdValid,
    output var  logic [15:0] primaryCmdWord,
    output var  logic [15:0] auxCmdWrite
);
    initial
    begin
        cmdValid = 1'b0;
        primaryCmdWord = 16'h0000;
        auxCmdWrite = 16'h0000;
    end
    // one word pair per exchange; bit 7 rises only by a 0 then 1 pair
    task automatic send(input logic [15:0] p, input logic [15:0] a);
        @(posedge clk);
        cmdValid <= 1'b1;
        primaryCmdWord <= p;
        auxCmdWrite <= a;
        @(posedge clk);
        cmdValid <= 1'b0;
        primaryCmdWord <= ~p;
        auxCmdWrite <= ~a;
    endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// testbench: command word decode and state word through the master
// assumes dcs_words, its checker and the master model are compiled
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dcs_pkg::*;
    logic         clk, reset, cmdValid, pulsesEnabled;
    logic [15:0]  primaryCmdWord, auxCmdWrite, a;
    logic [15:0]  aux_command_word, primary_state_word;
    logic [35:0]  srcConfig;
    dcs_cond_type cond;
    dcs_aux_type  auxFuncs;
    int           n_errors = 0;
    int           n_checks = 0;
    int           cycles = 0;

    dcs_master_model dcs_master_model_inst (
        .clk, .cmdValid, .primaryCmdWord, .auxCmdWrite);
    dcs_words dcs_words_inst (
        .clk, .reset, .cmdValid, .primaryCmdWord, .auxCmdWrite, .srcConfig,
        .cond, .aux_command_word, .primary_state_word, .auxFuncs,
        .pulsesEnabled);

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic go(input logic [15:0] p, input logic [15:0] w);
        dcs_master_model_inst.send(p, w);
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic fsm(input logic [15:0] p, input logic [15:0] f);
        go(p, 16'h2000);
        chk(primary_state_word, f | 16'hA800 | {10'h0, p[2:1], 4'h0});
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            $display("mismatch %0t: run did not finish", $time);
            print_verdict();
        end
    end

    initial
    begin
        reset = 1'b1;
        srcConfig = '0;
        cond = dcs_cond_type'(12'hC00);
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk(aux_command_word, AUX_RESET);
        repeat (3) @(negedge clk);
        chk(primary_state_word, 16'hA841);
        for (int i = 0; i < 17; i++)
        begin
            a = (i == 16) ? 16'hFFFF : 16'h0001 << i;
            go(16'h0006, a);
            chk(aux_command_word, a);
            chk({7'h0, auxFuncs}, {7'h0, a[3:0], a[8], a[9], a[11],
                a[12], !a[13]});
        end
        @(posedge clk) srcConfig <= 36'h00DC83215;
        go(16'h0006, 16'h0020);
        chk({7'h0, auxFuncs}, 16'h0021);
        @(posedge clk) srcConfig <= '0;
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk) cond <= dcs_cond_type'(12'hC00 | (12'h1 << i));
            repeat (2) @(negedge clk);
            chk(primary_state_word & 16'hFF80,
                16'hA800 ^ (16'h1 << (15 - i)));
        end
        @(posedge clk) cond <= dcs_cond_type'(12'hC00);
        fsm(16'h0007, 16'h0003);
        fsm(16'h000F, 16'h0006);
        chk({15'h0, pulsesEnabled}, 16'h0001);
        @(posedge clk) cond.faultActive <= 1'b1;
        fsm(16'h000F, 16'h0008);
        chk({15'h0, pulsesEnabled}, 16'h0000);
        @(posedge clk) cond.faultActive <= 1'b0;
        fsm(16'h0006, 16'h0008);
        fsm(16'h0080, 16'h0041);
        fsm(16'h0007, 16'h0041);
        fsm(16'h0006, 16'h0001);
        fsm(16'h0007, 16'h0003);
        print_verdict();
    end
endmodule
`default_nettype wire
